// ===== fobpc_gate.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : Glitch-free gate for one output, stepped by output clock edges
// Assumes : i_ck_rise is a one-cycle pulse per output clock period
// Notes   : Starts and stops only on whole clock cycles
//////////////////////////////////////////////////////////////////////////////
`default_nettype none
module fobpc_gate #(
  parameter int unsigned TAIL = 4
) (
  input  wire logic i_clk_sys,   // System clock
  input  wire logic i_rst_n,     // Async reset, active low
  input  wire logic i_ck_rise,   // Output clock rising edge pulse
  input  wire logic i_want,      // Requested enable
  input  wire logic i_kill,      // Immediate stop at period boundary
  output logic      o_run        // Gate open
);
  initial if (TAIL == 0 || TAIL > 15) $error("TAIL out of range");

  logic       run_ff, nxt_run;
  logic [3:0] tail_ff, nxt_tail;

  // Open at next edge, close after the tail of whole periods
  always_comb
  begin
    nxt_run  = run_ff;
    nxt_tail = tail_ff;
    if (i_ck_rise)
    begin
      if (i_kill)
      begin
        nxt_run  = 1'b0;
        nxt_tail = 4'h0;
      end
      else if (i_want)
      begin
        nxt_run  = 1'b1;
        nxt_tail = 4'h0;
      end
      else if (run_ff)
      begin
        if (tail_ff == 4'(TAIL))                     // Four whole periods after the first counted edge
        begin
          nxt_run  = 1'b0;
          nxt_tail = 4'h0;
        end
        else
        begin
          nxt_tail = tail_ff + 4'h1;
        end
      end
    end
  end

  // Gate state
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      run_ff  <= 1'b0;
      tail_ff <= 4'h0;
    end
    else
    begin
      run_ff  <= nxt_run;
      tail_ff <= nxt_tail;
    end
  end

  assign o_run = run_ff;

  // Gate changes only on an output clock edge
  gate_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $changed(run_ff) |-> $past(i_ck_rise)) else $error("gate moved mid-period");
endmodule
`default_nettype wire

// ===== fobpc_host.sv
// Purpose : Reference clock source beside the buffer
// Assumes : 160 ns period, unrelated in phase to i_clk_sys
// Notes   : Complement is the inverse of the true clock
`default_nettype none
module fobpc_host (
  input  wire logic i_run, // Clock enable
  output logic      o_ck,  // Output clock
  output logic      o_ckc  // Complement clock
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////
  // Free-running clock; parks low only when told to stop
  initial
  begin
    o_ck = 1'b0;
    #3;
    forever
    begin
      #80;
      o_ck = i_run ? ~o_ck : 1'b0;
    end
  end
  assign o_ckc = ~o_ck;
endmodule
`default_nettype wire

// ===== fobpc_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : Shared constants of the fanout output enable and power control
// Assumes : System clock of 100 MHz
// Notes   : All users refer to names as fobpc_pkg::name
//////////////////////////////////////////////////////////////////////////////
`default_nettype none
package fobpc_pkg;
  // Output count and pin-gated range
  localparam int unsigned NUM_OUT      = 20;
  localparam int unsigned PIN_LO       = 5;
  localparam int unsigned PIN_HI       = 12;
  localparam int unsigned NUM_PIN      = 8;
  // Gating latencies in output clock periods
  localparam int unsigned MIN_TAIL_CLK = 4;
  localparam int unsigned MAX_LAT_CLK  = 10;
  localparam int unsigned PD_SAMPLES   = 2;
  // Timing in system clock
  localparam int unsigned SYS_CLK_MHZ  = 100;
  localparam int unsigned TSTABLE_US   = 1800;
  localparam int unsigned TSTABLE_CYC  = TSTABLE_US * SYS_CLK_MHZ - 1;
  localparam int unsigned PGHIGH_US    = 300;
  localparam int unsigned PGHIGH_CYC   = PGHIGH_US * SYS_CLK_MHZ - 1;
  // Management framing
  localparam logic [7:0]  SMB_ADDR_BASE = 8'h68;
  localparam int unsigned CMD_MODE_BIT = 7;
  localparam int unsigned CNT_MIN      = 1;
  localparam int unsigned CNT_MAX      = 32;
  localparam int unsigned NUM_ADDR     = 9;
  // Reset value of register enables (all enabled)
  localparam logic [19:0] OE_REG_RST   = 20'hfffff;
  // Tri-level code
  localparam logic [1:0]  TRI_LOW      = 2'h0;
  localparam logic [1:0]  TRI_MID      = 2'h1;
  localparam logic [1:0]  TRI_HIGH     = 2'h2;
endpackage
`default_nettype wire

// ===== fobpc_smb.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : Management slave framing: address match, command, count, data
// Assumes : Bus lines already synchronised; open-drain data output
// Notes   : Registers are OE bytes 0..2; other indices read zero
//////////////////////////////////////////////////////////////////////////////
`default_nettype none
module fobpc_smb (
  input  wire logic        i_clk_sys,   // System clock
  input  wire logic        i_rst_n,     // Async reset, active low
  input  wire logic        i_scl,       // Synchronised bus clock
  input  wire logic        i_sda,       // Synchronised bus data
  input  wire logic [6:0]  i_addr,      // Strapped slave address
  output logic             o_sda_oe,    // Pull data low
  output logic [19:0]      o_oe_reg,    // Register enable bits
  output logic             o_cnt_err    // Illegal block count seen
);
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_ADDR = 3'h1, S_CMD = 3'h2, S_CNT = 3'h3,
    S_WDAT = 3'h4, S_RDAT = 3'h5, S_ACK = 3'h6, S_MACK = 3'h7
  } fobpc_smb_t;

  fobpc_smb_t  st_ff, nxt_st, ret_ff, nxt_ret;
  logic        scl_d_ff, sda_d_ff;
  logic [7:0]  sh_ff, nxt_sh;
  logic [3:0]  bit_ff, nxt_bit;
  logic [6:0]  idx_ff, nxt_idx;
  logic [5:0]  cnt_ff, nxt_cnt;
  logic        byte_ff, nxt_byte, rd_ff, nxt_rd, ack_ff, nxt_ack, err_ff, nxt_err;
  logic [19:0] oe_ff, nxt_oe;
  logic        scl_r, scl_f, start, stop;

  localparam int unsigned CMD_BIT = fobpc_pkg::CMD_MODE_BIT;

  assign scl_r = i_scl & ~scl_d_ff;
  assign scl_f = ~i_scl & scl_d_ff;
  assign start = i_scl & scl_d_ff & sda_d_ff & ~i_sda;
  assign stop  = i_scl & scl_d_ff & ~sda_d_ff & i_sda;

  // Read one register byte by index
  function automatic logic [7:0] rd_reg(input logic [6:0] idx, input logic [19:0] oe);
    case (idx)
      7'h0:    rd_reg = oe[7:0];
      7'h1:    rd_reg = oe[15:8];
      7'h2:    rd_reg = {4'h0, oe[19:16]};
      default: rd_reg = 8'h00;
    endcase
  endfunction

  // Framing sequencer
  always_comb
  begin
    nxt_st = st_ff; nxt_ret = ret_ff; nxt_sh = sh_ff; nxt_bit = bit_ff;
    nxt_idx = idx_ff; nxt_cnt = cnt_ff; nxt_byte = byte_ff; nxt_rd = rd_ff;
    nxt_ack = ack_ff; nxt_err = err_ff; nxt_oe = oe_ff;
    if (stop)
    begin
      nxt_st = S_IDLE; nxt_ack = 1'b0;
    end
    else if (start)
    begin
      nxt_st = S_ADDR; nxt_bit = 4'h0; nxt_ack = 1'b0;       // Repeated start allowed
    end
    else
    begin
      unique case (st_ff)
        S_IDLE: ;
        S_ADDR, S_CMD, S_CNT, S_WDAT:
          if (scl_r)
          begin
            nxt_sh  = {sh_ff[6:0], i_sda};
            nxt_bit = bit_ff + 4'h1;
          end
          else if (scl_f && bit_ff == 4'h8)
          begin
            nxt_bit = 4'h0;
            nxt_ack = 1'b1;
            nxt_st  = S_ACK;
            unique case (st_ff)
              S_ADDR:
                if (sh_ff[7:1] != i_addr)
                begin
                  nxt_ack = 1'b0; nxt_st = S_IDLE;               // Not our address
                end
                else
                begin
                  nxt_rd  = sh_ff[0];
                  nxt_ret = sh_ff[0] ? S_RDAT : S_CMD;
                end
              S_CMD:
              begin
                nxt_idx  = sh_ff[6:0];                           // Start index from low bits
                nxt_byte = sh_ff[CMD_BIT];                       // Byte vs block select
                nxt_ret  = sh_ff[CMD_BIT] ? S_WDAT : S_CNT;      // Count follows in block mode
                nxt_cnt  = 6'h1;
              end
              S_CNT:
              begin
                if (sh_ff == 8'h00 || sh_ff > 8'(fobpc_pkg::CNT_MAX))
                begin
                  nxt_err = 1'b1; nxt_ack = 1'b0; nxt_ret = S_IDLE; // Count limits
                end
                else
                begin
                  nxt_cnt = 6'(sh_ff); nxt_ret = S_WDAT;
                end
              end
              default:
              begin
                unique case (idx_ff)
                  7'h0: nxt_oe[7:0]   = sh_ff;
                  7'h1: nxt_oe[15:8]  = sh_ff;
                  7'h2: nxt_oe[19:16] = sh_ff[3:0];
                  default: ;
                endcase
                nxt_idx = idx_ff + 7'h1;
                nxt_cnt = (cnt_ff == 6'h0) ? 6'h0 : cnt_ff - 6'h1;
                nxt_ret = (byte_ff || cnt_ff <= 6'h1) ? S_IDLE : S_WDAT;
              end
            endcase
          end
        S_ACK:
          if (scl_f)
          begin
            nxt_ack = 1'b0;
            nxt_st  = ret_ff;
            nxt_sh  = rd_reg(idx_ff, oe_ff);
          end
        S_RDAT:
          if (scl_f)
          begin
            nxt_sh  = {sh_ff[6:0], 1'b1};
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == 4'h7)
            begin
              nxt_st = S_MACK; nxt_bit = 4'h0;
            end
          end
        S_MACK:
          if (scl_r)
          begin
            nxt_idx = idx_ff + 7'h1;
            nxt_st  = i_sda ? S_IDLE : S_ACK;                    // Master NAK ends read
            nxt_ret = S_RDAT;
          end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= S_IDLE; ret_ff <= S_IDLE; sh_ff <= 8'h00; bit_ff <= 4'h0;
      idx_ff <= 7'h00; cnt_ff <= 6'h0; byte_ff <= 1'b0; rd_ff <= 1'b0;
      ack_ff <= 1'b0; err_ff <= 1'b0; scl_d_ff <= 1'b1; sda_d_ff <= 1'b1;
      oe_ff <= fobpc_pkg::OE_REG_RST;                            // Enables reset set
    end
    else
    begin
      st_ff <= nxt_st; ret_ff <= nxt_ret; sh_ff <= nxt_sh; bit_ff <= nxt_bit;
      idx_ff <= nxt_idx; cnt_ff <= nxt_cnt; byte_ff <= nxt_byte; rd_ff <= nxt_rd;
      ack_ff <= nxt_ack; err_ff <= nxt_err; scl_d_ff <= i_scl; sda_d_ff <= i_sda;
      oe_ff <= nxt_oe;
    end
  end

  // Drive low for ack or a zero data bit
  assign o_sda_oe  = ack_ff | ((st_ff == S_RDAT) & ~sh_ff[7]);
  assign o_oe_reg  = oe_ff;
  assign o_cnt_err = err_ff;
endmodule
`default_nettype wire

// ===== fobpc_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : Output enable gating and power control of a 20-output fanout
// Assumes : Output clock and all pins are asynchronous to i_clk_sys
// Notes   : Outputs are gate levels per pair; analog drive is outside
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`default_nettype none
module fobpc_top #(
  parameter int unsigned NUM_OUT     = fobpc_pkg::NUM_OUT,
  parameter int unsigned TSTABLE_CYC = fobpc_pkg::TSTABLE_CYC,
  parameter int unsigned PGHIGH_CYC  = fobpc_pkg::PGHIGH_CYC
) (
  input  wire logic                i_clk_sys,                     // System clock, 100 MHz
  input  wire logic                i_rst_n,                       // Async reset, active low
  input  wire logic                i_buffered_output_clock,       // Output clock pin
  input  wire logic                i_buffered_output_clock_complement, // Complement output clock pin
  input  wire logic [7:0]          i_output_enable_pin_n,         // Pins for outputs 12..5
  input  wire logic                i_power_good_pin,              // Power good / power down pin
  input  wire logic [1:0]          i_address_select_low,          // Tri-level code of low select pin
  input  wire logic [1:0]          i_address_select_high,         // Tri-level code of high select pin
  input  wire logic                i_smb_clk,                     // Bus clock pin
  input  wire logic                i_smb_data,                    // Bus data pin level
  output logic                     o_smb_data,                    // Bus data output level
  output logic                     o_smb_data_oe,                 // Bus data output enable
  output logic [NUM_OUT-1:0]       o_out_run,                     // Output toggling
  output logic [NUM_OUT-1:0]       o_out_park_high,               // Parked output driven high
  output logic                     o_power_save,                  // Power saving mode
  output logic                     o_clocks_stable,               // Outputs stable
  output logic [6:0]               o_slave_addr,                  // Captured slave address
  output logic                     o_cnt_err                      // Illegal block count seen
);
  initial if (NUM_OUT < fobpc_pkg::PIN_HI + 1) $error("NUM_OUT too small");
  initial if (TSTABLE_CYC >= 2**18 || PGHIGH_CYC >= 2**15) $error("Timer count too wide");

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [11:0] s1_ff, s2_ff;
  logic        ckc_d_ff, ck_d_ff;
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_ff    <= 12'hfff;
      s2_ff    <= 12'hfff;
      ckc_d_ff <= 1'b1;                                          // Match synchroniser reset, no false edge
      ck_d_ff  <= 1'b1;
    end
    else
    begin
      s1_ff    <= {i_smb_clk, i_smb_data, i_buffered_output_clock_complement,
                   i_buffered_output_clock, i_output_enable_pin_n};
      s2_ff    <= s1_ff;
      ckc_d_ff <= s2_ff[9];
      ck_d_ff  <= s2_ff[8];
    end
  end

  logic [7:0] pin_n_s;
  logic       ck_s, ckc_s, scl_s, sda_s;
  assign pin_n_s = s2_ff[7:0];
  assign ck_s    = s2_ff[8];
  assign ckc_s   = s2_ff[9];
  assign sda_s   = s2_ff[10];
  assign scl_s   = s2_ff[11];

  // Power good goes through its own pair
  logic       pg1_ff, pg2_ff;
  logic [3:0] sa1_ff, sa2_ff;
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pg1_ff <= 1'b0;
      pg2_ff <= 1'b0;
      sa1_ff <= 4'h0;
      sa2_ff <= 4'h0;
    end
    else
    begin
      pg1_ff <= i_power_good_pin;
      pg2_ff <= pg1_ff;
      sa1_ff <= {i_address_select_high, i_address_select_low};   // Straps are pins too
      sa2_ff <= sa1_ff;
    end
  end

  // Output clock edges
  logic ck_rise, ckc_rise, ckc_fall;
  assign ck_rise  = ck_s & ~ck_d_ff;
  assign ckc_rise = ckc_s & ~ckc_d_ff;
  assign ckc_fall = ~ckc_s & ckc_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode from tri-level straps
  function automatic logic [6:0] strap_addr(input logic [1:0] lo, input logic [1:0] hi);
    logic [3:0] sel;
    sel = 4'((hi == fobpc_pkg::TRI_HIGH ? 2 : hi == fobpc_pkg::TRI_MID ? 1 : 0) * 3 +
             (lo == fobpc_pkg::TRI_HIGH ? 2 : lo == fobpc_pkg::TRI_MID ? 1 : 0));
    strap_addr = fobpc_pkg::SMB_ADDR_BASE[7:1] + 7'(sel);   // Nine addresses
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Power good capture and power-down tracking
  logic        seen_ff, nxt_seen;
  logic [6:0]  addr_ff, nxt_addr;
  logic [1:0]  pdn_cnt_ff, nxt_pdn_cnt;
  logic        pdn_ff, nxt_pdn;
  logic        pg_d_ff;
  logic [17:0] stab_ff, nxt_stab;
  logic [14:0] park_ff, nxt_park;
  logic        parkh_ff, nxt_parkh;

  always_comb
  begin
    nxt_seen    = seen_ff;
    nxt_addr    = addr_ff;
    nxt_pdn_cnt = pdn_cnt_ff;
    nxt_pdn     = pdn_ff;
    nxt_stab    = stab_ff;
    nxt_park    = park_ff;
    nxt_parkh   = parkh_ff;
    if (pg2_ff && !pg_d_ff && !seen_ff)
    begin
      nxt_seen = 1'b1;
      nxt_addr = strap_addr(sa2_ff[1:0], sa2_ff[3:2]);            // Strap capture
    end
    // Count consecutive low samples on complement rising edges
    if (seen_ff && ckc_rise)
      nxt_pdn_cnt = pg2_ff ? 2'h0 : ((pdn_cnt_ff == 2'(fobpc_pkg::PD_SAMPLES)) ? pdn_cnt_ff : pdn_cnt_ff + 2'h1);
    if (seen_ff && !pg2_ff && ckc_fall && pdn_cnt_ff == 2'(fobpc_pkg::PD_SAMPLES))
    begin
      nxt_pdn   = 1'b1;                                        // Stop at next fall
      nxt_parkh = 1'b0;
    end
    if (pg2_ff && seen_ff)
    begin
      if (pdn_ff)
      begin
        nxt_pdn   = 1'b0;
        nxt_park  = 15'h0;
        nxt_stab  = 18'h0;
      end
    end
    if (pg2_ff)
    begin
      if (stab_ff != 18'(TSTABLE_CYC))
        nxt_stab = stab_ff + 18'h1;                            // Stable within bound
      if (!nxt_parkh && park_ff != 15'(PGHIGH_CYC))
        nxt_park = park_ff + 15'h1;
      else if (!parkh_ff)
        nxt_parkh = 1'b1;                                      // Park high bound
    end
    else
    begin
      nxt_stab = 18'h0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      seen_ff    <= 1'b0;
      addr_ff    <= 7'h00;
      pdn_cnt_ff <= 2'h0;
      pdn_ff     <= 1'b1;
      pg_d_ff    <= 1'b0;
      stab_ff    <= 18'h0;
      park_ff    <= 15'h0;
      parkh_ff   <= 1'b0;
    end
    else
    begin
      seen_ff    <= nxt_seen;
      addr_ff    <= nxt_addr;
      pdn_cnt_ff <= nxt_pdn_cnt;
      pdn_ff     <= nxt_pdn;
      pg_d_ff    <= pg2_ff;
      stab_ff    <= nxt_stab;
      park_ff    <= nxt_park;
      parkh_ff   <= nxt_parkh;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Management slave
  logic [19:0] oe_reg;
  logic        sda_oe;
  fobpc_smb u_smb (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_scl     (scl_s),
    .i_sda     (sda_s),
    .i_addr    (addr_ff),
    .o_sda_oe  (sda_oe),
    .o_oe_reg  (oe_reg),
    .o_cnt_err (o_cnt_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-output enable gates
  logic [NUM_OUT-1:0] want, run;
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++)
    begin : g_out
      if (g >= fobpc_pkg::PIN_LO && g <= fobpc_pkg::PIN_HI)
      begin : g_pin
        assign want[g] = oe_reg[g] & ~pin_n_s[g - fobpc_pkg::PIN_LO]; // Bit one and pin zero
      end
      else
      begin : g_reg
        assign want[g] = (g < 20) ? oe_reg[g % 20] : 1'b0;     // Register bit only
      end
      fobpc_gate #(
        .TAIL (fobpc_pkg::MIN_TAIL_CLK)
      ) u_gate (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_ck_rise (ck_rise),
        .i_want    (want[g]),                                  // Restart next edge, four-clock tail
        .i_kill    (nxt_pdn),                                  // Stops on the fall that sets it
        .o_run     (run[g])
      );
    end
  endgenerate

  // Outputs
  assign o_out_run       = run;
  assign o_out_park_high = {NUM_OUT{parkh_ff & ~pdn_ff}} & ~run;
  assign o_power_save    = pdn_ff;
  assign o_clocks_stable = stab_ff == 18'(TSTABLE_CYC);
  assign o_slave_addr    = addr_ff;
  assign o_smb_data      = 1'b0;
  assign o_smb_data_oe   = sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence pd_two_low_s;
    ckc_rise && seen_ff && pdn_cnt_ff == 2'h1 && !pg2_ff;
  endsequence
  pd_stop_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(pdn_ff) |-> $past(ckc_fall)) else $error("power-down not on falling edge");
  pd_low_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (pdn_ff && $past(pdn_ff)) |-> (run == '0)) else $error("outputs not low in power-down");
  en_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (ck_rise && !want[5] && !nxt_pdn && !run[5]) |=> !run[5]) else $error("disabled output started");
  en_start_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (ck_rise && want[0] && !nxt_pdn) |=> run[0]) else $error("output not restarted");
  en_tail_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (run[6] && !want[6] && !nxt_pdn && ck_rise &&
     g_out[6].u_gate.tail_ff != 4'(fobpc_pkg::MIN_TAIL_CLK)) |=> run[6]) else $error("tail cut short");
  strap_once_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    seen_ff |=> $stable(addr_ff)) else $error("strap recaptured");
  stab_clr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !pg2_ff |=> !o_clocks_stable) else $error("stable without power good");
  addr_rng_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    seen_ff |-> addr_ff < fobpc_pkg::SMB_ADDR_BASE[7:1] + 7'(fobpc_pkg::NUM_ADDR)) else $error("address out of range");
  sync_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    pd_two_low_s |-> ##0 !pdn_ff) else $error("power-down before two samples");
endmodule
`default_nettype wire

// ===== fobpc_top_tb.sv
// Purpose : Self-checking bench of output gating and power control
// Assumes : Output clock 160 ns, i.e. 16 system cycles
// Notes   : Bus host writes, reads back and sends a bad count; stable and park counts shortened to 50
`default_nettype none
module fobpc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk_sys, i_rst_n, pg, ck, ckc, ck_run;
  logic        psave, stable, sda, sda_oe, cnt_err;
  logic [7:0]  oe_n;
  logic [1:0]  sa_lo, sa_hi;
  logic [19:0] run, park;
  logic [6:0]  addr;
  logic        scl, sda_m, sda_ln, a;
  logic [7:0]  q;
  assign sda_ln = sda_m & ~sda_oe;   // Open-drain bus line with pull-up
  int          n_errors, total_checks, cyc, n;
  ////////////////////////////////////////
  // Design and clock source
  fobpc_host u_host (.i_run(ck_run), .o_ck(ck), .o_ckc(ckc));
  fobpc_top #(.TSTABLE_CYC(50), .PGHIGH_CYC(50)) DUT (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_buffered_output_clock(ck),
    .i_buffered_output_clock_complement(ckc),
    .i_output_enable_pin_n(oe_n), .i_power_good_pin(pg),
    .i_address_select_low(sa_lo), .i_address_select_high(sa_hi),
    .i_smb_clk(scl), .i_smb_data(sda_ln),
    .o_smb_data(sda), .o_smb_data_oe(sda_oe),
    .o_out_run(run), .o_out_park_high(park),
    .o_power_save(psave), .o_clocks_stable(stable),
    .o_slave_addr(addr), .o_cnt_err(cnt_err));
  ////////////////////////////////////////
  // System clock
  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // Compare and count
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Counts and verdict
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Cycles until output idx reaches level v, at most lim
  task automatic wait_run(input int idx, input logic v, input int lim);
    n = 0;
    while (run[idx] !== v && n < lim)
    begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
  endtask
  // Bus host: third of a bit, eight system cycles
  task automatic smb_half();
    repeat (8) @(posedge i_clk_sys);
  endtask
  task automatic smb_bit(input logic b, output logic r);
    sda_m <= b;
    smb_half();
    scl <= 1'b1;
    smb_half();
    r = sda_ln;
    scl <= 1'b0;
    smb_half();
  endtask
  task automatic smb_start();
    sda_m <= 1'b1;
    smb_half();
    scl <= 1'b1;
    smb_half();
    sda_m <= 1'b0;
    smb_half();
    scl <= 1'b0;
    smb_half();
  endtask
  task automatic smb_stop();
    sda_m <= 1'b0;
    smb_half();
    scl <= 1'b1;
    smb_half();
    sda_m <= 1'b1;
    smb_half();
  endtask
  // Eight data bits then the ninth (acknowledge) bit
  task automatic smb_byte(input logic [7:0] d, input logic m, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--)
      smb_bit(d[i], r[i]);
    smb_bit(m, k);
  endtask
  // Hang guard
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      conclude();
    end
  end
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    i_rst_n = 1'b0;
    pg = 1'b0;
    oe_n = 8'hff;
    ck_run = 1'b1;
    scl = 1'b1;
    sda_m = 1'b1;
    sa_lo = fobpc_pkg::TRI_MID;
    sa_hi = fobpc_pkg::TRI_HIGH;
    repeat (12) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (40) @(posedge i_clk_sys);
    chk(run, 20'h00000);
    chk({19'h0, psave}, 20'h00001);
    pg <= 1'b1;
    repeat (200) @(posedge i_clk_sys);
    #1;
    chk({13'h0, addr}, 20'h0003b);
    chk(run, 20'hfe01f);
    chk({18'h0, stable, psave}, 20'h00002);
    @(posedge i_clk_sys);
    smb_start();
    smb_byte(8'h76, 1'b1, q, a);
    chk(20'(a), 20'h0);
    smb_byte(8'h80, 1'b1, q, a);
    smb_byte(8'he0, 1'b1, q, a);
    smb_stop();
    repeat (100) @(posedge i_clk_sys);
    chk(run, 20'hfe000);
    smb_start();
    smb_byte(8'h76, 1'b1, q, a);
    smb_byte(8'h80, 1'b1, q, a);
    smb_start();
    smb_byte(8'h77, 1'b1, q, a);
    smb_byte(8'hff, 1'b1, q, a);
    chk(20'(q), 20'h000e0);
    smb_stop();
    smb_start();
    smb_byte(8'h76, 1'b1, q, a);
    smb_byte(8'h00, 1'b1, q, a);
    smb_byte(8'h02, 1'b1, q, a);
    smb_byte(8'hff, 1'b1, q, a);
    smb_byte(8'hff, 1'b1, q, a);
    chk(20'(a), 20'h0);
    smb_stop();
    repeat (40) @(posedge i_clk_sys);
    chk(run, 20'hfe01f);
    smb_start();
    smb_byte(8'h76, 1'b1, q, a);
    smb_byte(8'h00, 1'b1, q, a);
    smb_byte(8'h21, 1'b1, q, a);
    chk(20'(a), 20'h1);
    smb_stop();
    chk(20'(cnt_err), 20'h1);
    @(posedge i_clk_sys);
    oe_n <= 8'h00;
    wait_run(12, 1'b1, 300);
    chk(20'(n <= 165), 20'h1);
    chk(run, 20'hfffff);
    @(posedge i_clk_sys);
    oe_n <= 8'hff;
    wait_run(12, 1'b0, 300);
    chk(20'(n >= 60), 20'h1);
    chk(20'(n <= 165), 20'h1);
    chk(run, 20'hfe01f);
    @(posedge i_clk_sys);
    pg <= 1'b0;
    sa_lo <= fobpc_pkg::TRI_LOW;
    wait_run(0, 1'b0, 300);
    chk(20'(n >= 20 && n <= 60), 20'h1);
    chk(20'({run, psave} == {20'h0, 1'b1}), 20'h1);
    pg <= 1'b1;
    repeat (55) @(posedge i_clk_sys);
    #1;
    chk(park | run, 20'hfffff);
    repeat (60) @(posedge i_clk_sys);
    #1;
    chk({18'h0, stable, psave}, 20'h00002);
    chk({13'h0, addr}, 20'h0003b);
    conclude();
  end
endmodule
`default_nettype wire
